// File: rtl/rtc_calendar_pkg.sv
// Constants, types and register map for the BCD time and date counter
package rtc_calendar_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADDR_CONTROL_1    = 8'h00;
   localparam logic [7:0] ADDR_SECONDS      = 8'h02;
   localparam logic [7:0] ADDR_MINUTES      = 8'h03;
   localparam logic [7:0] ADDR_HOURS        = 8'h04;
   localparam logic [7:0] ADDR_DAY_OF_MONTH = 8'h05;
   localparam logic [7:0] ADDR_WEEKDAY      = 8'h06;
   localparam logic [7:0] ADDR_MONTH        = 8'h07;
   localparam logic [7:0] ADDR_YEAR         = 8'h08;

   // ****************************************
   // Field positions and masks
   // ****************************************
   localparam int         CTRL_STOP_BIT    = 5;
   localparam int         CTRL_HOUR12_BIT  = 2;
   localparam int         SEC_FLAG_BIT     = 7;
   localparam int         HOUR_PM_BIT      = 5;
   localparam logic [7:0] CTRL_MASK        = 8'h24;
   localparam logic [7:0] MASK_SEVEN       = 8'h7f;
   localparam logic [7:0] MASK_SIX         = 8'h3f;
   localparam logic [7:0] MASK_FIVE        = 8'h1f;
   localparam logic [7:0] MASK_THREE       = 8'h07;
   localparam logic [7:0] CTRL_RESET       = 8'h00;

   // ****************************************
   // BCD limits
   // ****************************************
   localparam logic [7:0] BCD_ZERO   = 8'h00;
   localparam logic [7:0] BCD_ONE    = 8'h01;
   localparam logic [7:0] BCD_59     = 8'h59;
   localparam logic [7:0] BCD_23     = 8'h23;
   localparam logic [7:0] BCD_11     = 8'h11;
   localparam logic [7:0] BCD_12     = 8'h12;
   localparam logic [7:0] BCD_99     = 8'h99;
   localparam logic [7:0] BCD_28     = 8'h28;
   localparam logic [7:0] BCD_29     = 8'h29;
   localparam logic [7:0] BCD_30     = 8'h30;
   localparam logic [7:0] BCD_31     = 8'h31;
   localparam logic [7:0] MONTH_FEB  = 8'h02;
   localparam logic [7:0] MONTH_APR  = 8'h04;
   localparam logic [7:0] MONTH_JUN  = 8'h06;
   localparam logic [7:0] MONTH_SEP  = 8'h09;
   localparam logic [7:0] MONTH_NOV  = 8'h11;
   localparam logic [2:0] WDAY_LAST  = 3'h6;
   localparam logic [3:0] NIBBLE_9   = 4'h9;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ      = 100_000_000;
   localparam int TICK_HZ     = 1;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam int DIV_W       = 27;
   localparam logic [DIV_W-1:0] DIV_ONE = 27'h0000001;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] wday;
      logic [7:0] month;
      logic [7:0] year;
   } time_date_t;

   typedef enum logic [1:0] {
      TK_IDLE  = 2'b00,
      TK_COUNT = 2'b01,
      TK_STOP  = 2'b11
   } tick_state_t;

endpackage

// File: rtl/bcd_time_date_counter.sv
// BCD time and calendar counter chain with its register file
`timescale 1ns/1ps
module bcd_time_date_counter
   import rtc_calendar_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
)
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire reg_req_t   req,
   output logic [7:0]      rdata,
   output logic            rvalid,
   output logic            stopped,
   output logic            second_tick
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      r = v;
      if (v[3:0] >= NIBBLE_9)
      begin
         r[3:0] = 4'h0;
         r[7:4] = v[7:4] + 4'h1;
      end
      else
      begin
         r[3:0] = v[3:0] + 4'h1;
      end
      return r;
   endfunction

   function automatic logic hit(input reg_req_t q, input logic [7:0] a);
      return q.wr_en && (q.addr == a);
   endfunction

   // ****************************************
   // State
   // ****************************************
   logic [7:0]       ctrl_ff;
   logic             flag_ff;
   time_date_t       td_ff;
   time_date_t       nxt_td;
   logic [DIV_W-1:0] div_ff;
   logic [DIV_W-1:0] nxt_div;
   tick_state_t      tk_ff;
   tick_state_t      nxt_tk;
   logic             tick_ff;
   logic [7:0]       rdata_ff;
   logic             rvalid_ff;
   logic             stopped_ff;

   wire  stop_w   = ctrl_ff[CTRL_STOP_BIT];
   wire  mode12_w = ctrl_ff[CTRL_HOUR12_BIT];

   // ****************************************
   // Seconds tick divider
   // ****************************************
   wire div_end_w = (div_ff >= DIV_W'(TICK_DIV - 1));
   always_comb
   begin
      nxt_tk  = tk_ff;
      nxt_div = div_ff;
      case (tk_ff)
         TK_IDLE:
         begin
            nxt_div = '0;
            nxt_tk  = stop_w ? TK_STOP : TK_COUNT;
         end
         TK_COUNT:
         begin
            if (stop_w)
            begin
               nxt_div = '0;
               nxt_tk  = TK_STOP;
            end
            else
               nxt_div = div_end_w ? '0 : div_ff + DIV_ONE;
         end
         TK_STOP:
         begin
            nxt_div = '0;
            if (!stop_w)
               nxt_tk = TK_COUNT;
         end
         default:
         begin
            nxt_div = '0;
            nxt_tk  = TK_IDLE;
         end
      endcase
   end
   wire tick_w = (tk_ff == TK_COUNT) && !stop_w && div_end_w;

   // ****************************************
   // Carry chain
   // ****************************************
   wire leap_w   = (td_ff.year[0] == 1'b0) && (td_ff.year[1] == td_ff.year[4]);
   wire is_feb_w = (td_ff.month == MONTH_FEB);
   wire is30_w   = (td_ff.month == MONTH_APR) || (td_ff.month == MONTH_JUN) ||
                   (td_ff.month == MONTH_SEP) || (td_ff.month == MONTH_NOV);
   wire [7:0] mlen_w = is_feb_w ? (leap_w ? BCD_29 : BCD_28) : (is30_w ? BCD_30 : BCD_31);

   wire sec_wrap_w  = (td_ff.sec[6:0] >= BCD_59[6:0]);
   wire min_wrap_w  = (td_ff.min >= BCD_59);
   wire [4:0] h12_w = td_ff.hour[4:0];
   wire pm_w        = td_ff.hour[HOUR_PM_BIT];
   wire [7:0] h12_inc_w = bcd_inc({3'b000, h12_w});
   wire hour_wrap_w = mode12_w ? (pm_w && h12_w == BCD_11[4:0])
                               : (td_ff.hour[5:0] >= BCD_23[5:0]);
   wire day_wrap_w  = (td_ff.day >= mlen_w);
   wire mon_wrap_w  = (td_ff.month >= BCD_12);

   wire c_min_w  = tick_w && sec_wrap_w;
   wire c_hour_w = c_min_w && min_wrap_w;
   wire c_day_w  = c_hour_w && hour_wrap_w;
   wire c_mon_w  = c_day_w && day_wrap_w;
   wire c_year_w = c_mon_w && mon_wrap_w;

   logic [7:0] hour_inc;
   always_comb
   begin
      hour_inc = td_ff.hour;
      if (mode12_w)
      begin
         if (h12_w == BCD_12[4:0])
            hour_inc = {2'b00, pm_w, BCD_ONE[4:0]};
         else if (h12_w == BCD_11[4:0])
            hour_inc = {2'b00, ~pm_w, BCD_12[4:0]};
         else
            hour_inc = {2'b00, pm_w, h12_inc_w[4:0]};
      end
      else
         hour_inc = hour_wrap_w ? BCD_ZERO : bcd_inc(td_ff.hour);
   end

   always_comb
   begin
      nxt_td = td_ff;
      if (tick_w)
         nxt_td.sec = sec_wrap_w ? BCD_ZERO : bcd_inc(td_ff.sec & MASK_SEVEN);
      if (c_min_w)
         nxt_td.min = min_wrap_w ? BCD_ZERO : bcd_inc(td_ff.min);
      if (c_hour_w)
         nxt_td.hour = hour_inc;
      if (c_day_w)
      begin
         nxt_td.day  = day_wrap_w ? BCD_ONE : bcd_inc(td_ff.day);
         nxt_td.wday = (td_ff.wday[2:0] >= WDAY_LAST) ? BCD_ZERO
                                                      : {5'b0, td_ff.wday[2:0] + 3'h1};
      end
      if (c_mon_w)
         nxt_td.month = mon_wrap_w ? BCD_ONE : bcd_inc(td_ff.month);
      if (c_year_w)
         nxt_td.year = (td_ff.year >= BCD_99) ? BCD_ZERO : bcd_inc(td_ff.year);
      // Software writes win over the count in the same cycle
      if (hit(req, ADDR_SECONDS))
         nxt_td.sec = {1'b0, req.wdata[6:0]};
      if (hit(req, ADDR_MINUTES))
         nxt_td.min = req.wdata & MASK_SEVEN;
      if (hit(req, ADDR_HOURS))
         nxt_td.hour = req.wdata & MASK_SIX;
      if (hit(req, ADDR_DAY_OF_MONTH))
         nxt_td.day = req.wdata & MASK_SIX;
      if (hit(req, ADDR_WEEKDAY))
         nxt_td.wday = req.wdata & MASK_THREE;
      if (hit(req, ADDR_MONTH))
         nxt_td.month = req.wdata & MASK_FIVE;
      if (hit(req, ADDR_YEAR))
         nxt_td.year = req.wdata;
   end

   // ****************************************
   // Read data
   // ****************************************
   logic [7:0] rd_mux;
   always_comb
   begin
      case (req.addr)
         ADDR_CONTROL_1:    rd_mux = ctrl_ff;
         ADDR_SECONDS:      rd_mux = {flag_ff, td_ff.sec[6:0]};
         ADDR_MINUTES:      rd_mux = td_ff.min & MASK_SEVEN;
         ADDR_HOURS:        rd_mux = td_ff.hour & MASK_SIX;
         ADDR_DAY_OF_MONTH: rd_mux = td_ff.day & MASK_SIX;
         ADDR_WEEKDAY:      rd_mux = td_ff.wday & MASK_THREE;
         ADDR_MONTH:        rd_mux = td_ff.month & MASK_FIVE;
         ADDR_YEAR:         rd_mux = td_ff.year;
         default:           rd_mux = BCD_ZERO;
      endcase
   end

   // ****************************************
   // Flip-flops
   // ****************************************
   // Flag only clears by software write of zero; reset is the only setter
   wire nxt_flag = hit(req, ADDR_SECONDS) ? (flag_ff & req.wdata[SEC_FLAG_BIT]) : flag_ff;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_ff   <= CTRL_RESET;
         flag_ff   <= 1'b1;
         td_ff     <= '0;
         div_ff    <= '0;
         tk_ff     <= TK_IDLE;
         tick_ff   <= 1'b0;
         rdata_ff  <= BCD_ZERO;
         rvalid_ff <= 1'b0;
         stopped_ff <= 1'b0;
      end
      else
      begin
         if (hit(req, ADDR_CONTROL_1))
            ctrl_ff <= req.wdata & CTRL_MASK;
         flag_ff   <= nxt_flag;
         td_ff     <= nxt_td;
         div_ff    <= nxt_div;
         tk_ff     <= nxt_tk;
         tick_ff   <= tick_w;
         rdata_ff  <= req.rd_en ? rd_mux : rdata_ff;
         rvalid_ff <= req.rd_en;
         // Follows the state register edge for edge, but from a flop
         stopped_ff <= (nxt_tk == TK_STOP);
      end
   end

   assign rdata       = rdata_ff;
   assign rvalid      = rvalid_ff;
   assign stopped     = stopped_ff;
   assign second_tick = tick_ff;

endmodule

// File: verif/bcd_time_date_counter_chk.sv
// Port checker for the BCD time and date counter
`timescale 1ns/1ps
module bcd_time_date_counter_chk
   import rtc_calendar_pkg::*;
#(
   parameter int TICK_DIV = 10
)
(
   input wire logic       mclk,
   input wire logic       nrst,
   input wire reg_req_t   req,
   input wire logic [7:0] rdata,
   input wire logic       rvalid,
   input wire logic       stopped,
   input wire logic       second_tick
);
   // ****
   // Tick spacing
   // ****
   int gap_ff;
   always_ff @(posedge mclk or negedge nrst)
      if (!nrst)
         gap_ff <= TICK_DIV;
      else
         gap_ff <= second_tick ? 0 : gap_ff + 1;

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   wire rd_sec = req.rd_en && req.addr == ADDR_SECONDS;
   property p_sec; rd_sec |=> rdata[6:4] <= 3'h5 && rdata[3:0] <= 4'h9; endproperty
   a_sec: assert property (p_sec) else $error("seconds out of range");
   property p_min; req.rd_en && req.addr == ADDR_MINUTES |=> !rdata[7]; endproperty
   a_min: assert property (p_min) else $error("minutes bit 7 set");
   property p_hour; req.rd_en && req.addr == ADDR_HOURS |=> rdata[7:6] == 2'h0; endproperty
   a_hour: assert property (p_hour) else $error("hours upper bits set");
   property p_day; req.rd_en && req.addr == ADDR_DAY_OF_MONTH |=> rdata[7:6] == 2'h0; endproperty
   a_day: assert property (p_day) else $error("day upper bits set");
   property p_wday; req.rd_en && req.addr == ADDR_WEEKDAY |=> rdata <= 8'h06; endproperty
   a_wday: assert property (p_wday) else $error("weekday out of range");
   property p_month; req.rd_en && req.addr == ADDR_MONTH |=> rdata[7:5] == 3'h0; endproperty
   a_month: assert property (p_month) else $error("month upper bits set");
   property p_year; req.rd_en && req.addr == ADDR_YEAR |=> rdata[7:4] <= 4'h9 && rdata[3:0] <= 4'h9; endproperty
   a_year: assert property (p_year) else $error("year not BCD");
   property p_stop; req.wr_en && req.addr == ADDR_CONTROL_1 && req.wdata[5] |-> ##2 stopped; endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");
   property p_notick; stopped && $past(stopped) |-> !second_tick; endproperty
   a_notick: assert property (p_notick) else $error("tick while stopped");
   property p_gap; second_tick |-> gap_ff >= TICK_DIV - 1; endproperty
   a_gap: assert property (p_gap) else $error("ticks too close");
endmodule

bind bcd_time_date_counter bcd_time_date_counter_chk #(.TICK_DIV(TICK_DIV)) i_chk (.mclk(mclk), .nrst(nrst),
   .req(req), .rdata(rdata), .rvalid(rvalid), .stopped(stopped), .second_tick(second_tick));

// File: verif/bcd_time_date_counter_test.sv
// Self-checking testbench for the BCD time and date counter
`timescale 1ns/1ps
module bcd_time_date_counter_test
   import rtc_calendar_pkg::*;
;
   localparam int DIV = 10;
   logic       mclk;
   logic       nrst;
   reg_req_t   req;
   logic [7:0] rdata;
   logic       rvalid;
   logic       stopped;
   logic       second_tick;
   int         failures;
   int         comparisons;

   bcd_time_date_counter #(.TICK_DIV(DIV)) i_dut (.mclk(mclk), .nrst(nrst), .req(req), .rdata(rdata),
      .rvalid(rvalid), .stopped(stopped), .second_tick(second_tick));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1 req = '{1'b1, 1'b0, a, d};
      @(posedge mclk);
      #1 req = '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk);
      #1 req = '0;
      chk("rvalid", {7'h00, rvalid}, 8'h01);
      chk($sformatf("reg %h", a), rdata, exp);
   endtask

   // ****
   // Scenarios
   // ****
   task automatic test_reset();
      rd(ADDR_SECONDS, 8'h80);
      rd(ADDR_CONTROL_1, 8'h00);
      wr(8'h01, 8'hff);
      rd(8'h01, 8'h00);
      $display("test_reset done");
   endtask

   task automatic test_stop();
      int ticks;
      ticks = 0;
      wr(ADDR_CONTROL_1, 8'h20);
      @(posedge mclk);
      #1 chk("stopped", {7'h00, stopped}, 8'h01);
      repeat (3 * DIV)
      begin
         @(posedge mclk);
         #1 ticks += int'(second_tick);
      end
      chk("ticks", 8'(ticks), 8'h00);
      wr(ADDR_CONTROL_1, 8'h00);
      @(posedge mclk);
      #1 chk("running", {7'h00, stopped}, 8'h00);
      $display("test_stop done");
   endtask

   // Loads a time while stopped, lets exactly one tick through, reads back
   task automatic run_case(input logic [7:0] ctl, input logic [55:0] t, input logic [55:0] e);
      int n;
      n = 0;
      wr(ADDR_CONTROL_1, ctl | 8'h20);
      for (int k = 0; k < 7; k++)
         wr(ADDR_SECONDS + 8'(k), t[55-8*k -: 8]);
      wr(ADDR_CONTROL_1, ctl);
      while (second_tick !== 1'b1 && n < 4 * DIV)
      begin
         @(posedge mclk);
         #1 n++;
      end
      chk("tick", {7'h00, second_tick}, 8'h01);
      wr(ADDR_CONTROL_1, ctl | 8'h20);
      for (int k = 0; k < 7; k++)
         rd(ADDR_SECONDS + 8'(k), e[55-8*k -: 8]);
   endtask

   task automatic test_calendar();
      run_case(8'h00, 56'hd9592328060200, 56'h80000029000200);
      run_case(8'h00, 56'h59592328030201, 56'h00000001040301);
      run_case(8'h00, 56'h59592329010204, 56'h00000001020304);
      run_case(8'h00, 56'h59592331051299, 56'h00000001060100);
      run_case(8'h00, 56'h59592330000410, 56'h00000001010510);
      run_case(8'h04, 56'h59593131040120, 56'h00001201050220);
      run_case(8'h04, 56'h59591115020721, 56'h00003215020721);
      run_case(8'h04, 56'h59591215020721, 56'h00000115020721);
      $display("test_calendar done");
   endtask

   // Second reset with the flag cleared and control bits set
   task automatic test_rereset();
      @(posedge mclk);
      #1 nrst = 1'b0;
      repeat (2) @(posedge mclk);
      #1 nrst = 1'b1;
      rd(ADDR_SECONDS, 8'h80);
      rd(ADDR_CONTROL_1, 8'h00);
      $display("test_rereset done");
   endtask

   initial
   begin
      #20000;
      failures++;
      $display("BAD watchdog expected done seen timeout");
      stop_test();
   end

   initial
   begin
      failures = 0;
      comparisons = 0;
      req = '0;
      nrst = 1'b0;
      repeat (2) @(posedge mclk);
      #1 nrst = 1'b1;
      test_reset();
      test_stop();
      test_calendar();
      test_rereset();
      stop_test();
   end
endmodule
